// ===== inc/umaf_pkg.sv
package umaf_pkg;
    // *********************************************************************
    // Sampling figures
    // *********************************************************************
    localparam logic [4:0] UMAF_SPB_NORMAL = 5'h10;
    localparam logic [4:0] UMAF_SPB_DOUBLE = 5'h08;
    localparam logic [4:0] UMAF_FIRST_NORMAL = 5'h08;
    localparam logic [4:0] UMAF_FIRST_DOUBLE = 5'h04;
    localparam logic [4:0] UMAF_MID_NORMAL = 5'h09;
    localparam logic [4:0] UMAF_MID_DOUBLE = 5'h05;
    // Character size codes; code 7 selects nine data bits.
    localparam logic [2:0] UMAF_CSZ_NINE = 3'h7;
    localparam logic [3:0] UMAF_DATA_MIN = 4'h5;
    localparam logic [3:0] UMAF_DATA_MAX = 4'h9;
    localparam logic [3:0] UMAF_DP_MAX = 4'hA;
    localparam logic [3:0] UMAF_STOP_TWO = 4'h2;
    localparam logic [8:0] UMAF_DATA_RESET = 9'h000;
    localparam logic [15:0] UMAF_DIV_RESET = 16'h0000;
    localparam int UMAF_DATA_W = 9;

    typedef enum logic [1:0] {
        UMAF_IDLE = 2'b00,
        UMAF_START = 2'b01,
        UMAF_BITS = 2'b10,
        UMAF_STOP = 2'b11
    } umaf_state_type;
endpackage

// ===== inc/umaf_link_if.sv
`timescale 1ns/1ps
// Serial line between the frame sender and the filtering receiver.
interface umaf_link_if;
    logic serial_line;
    modport sender (output serial_line);
    modport receiver (input serial_line);
endinterface

// ===== src/umaf_tx.sv
`timescale 1ns/1ps
// *************************************************************************
// Frame sender for the far party
// *************************************************************************
module umaf_tx
    import umaf_pkg::*;
#(
    parameter int DIV_W = 16
) (
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    input wire logic clk_en_i,
    input wire logic [DIV_W-1:0] baud_div_i,
    input wire logic [2:0] char_size_select_i,
    input wire logic stop_bit_select_i,
    input wire logic parity_en_i,
    input wire logic parity_odd_i,
    input wire logic tx_start_i,
    input wire logic [7:0] tx_data_i,
    input wire logic tx_ninth_bit_i,
    output logic tx_busy_o,
    output logic tx_complete_flag_o,
    umaf_link_if.sender link
);
    // Bit pattern: start, data, optional parity, stops, shifted LSB first.
    logic [13:0] shreg;
    logic [3:0] bits_left;
    logic [DIV_W-1:0] div_cnt;
    logic [3:0] samp_cnt;
    logic line_q;
    logic busy;
    logic done;
    wire logic nine = (char_size_select_i == UMAF_CSZ_NINE);
    wire logic [3:0] nbits = nine ? UMAF_DATA_MAX :
        (UMAF_DATA_MIN + {2'b00, char_size_select_i[1:0]});
    wire logic [8:0] dmask = 9'h1FF >> (4'h9 - nbits);
    wire logic [8:0] dval = {tx_ninth_bit_i, tx_data_i} & dmask;
    wire logic par = ^dval ^ parity_odd_i;
    wire logic [3:0] nstop = stop_bit_select_i ? UMAF_STOP_TWO : 4'h1;
    wire logic [3:0] total = 4'h1 + nbits + {3'h0, parity_en_i} + nstop;
    // Positions above the character carry stop-level ones.
    wire logic [13:0] pat_d = {5'h1F, dval | ~dmask} << 1;
    wire logic [13:0] par_bit = {13'h0000, parity_en_i & par} << (nbits + 4'h1);
    wire logic [13:0] par_slot = {13'h0000, parity_en_i} << (nbits + 4'h1);
    wire logic [13:0] pattern = (pat_d & ~par_slot) | par_bit;
    wire logic bit_end = (div_cnt == '0) && (samp_cnt == 4'hF);

    // Sixteen-tick bit timing from the divider; line idles high.
    // ninth bit marks frame type.
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            shreg <= 14'h0000;
            bits_left <= 4'h0;
            div_cnt <= '0;
            samp_cnt <= 4'h0;
            line_q <= 1'b1;
            busy <= 1'b0;
            done <= 1'b0;
        end else if (clk_en_i) begin
            done <= 1'b0;
            if (!busy) begin
                if (tx_start_i) begin
                    shreg <= pattern >> 1;
                    line_q <= 1'b0;
                    bits_left <= total - 4'h1;
                    div_cnt <= baud_div_i;
                    samp_cnt <= 4'h0;
                    busy <= 1'b1;
                end
            end else if (div_cnt != '0) begin
                div_cnt <= div_cnt - 1'b1;
            end else begin
                div_cnt <= baud_div_i;
                samp_cnt <= samp_cnt + 4'h1;
                if (bit_end) begin
                    if (bits_left == 4'h0) begin
                        busy <= 1'b0;
                        done <= 1'b1;
                        line_q <= 1'b1;
                    end else begin
                        line_q <= shreg[0];
                        shreg <= {1'b1, shreg[13:1]};
                        bits_left <= bits_left - 4'h1;
                    end
                end
            end
        end
    end

    assign link.serial_line = line_q;
    assign tx_busy_o = busy;
    assign tx_complete_flag_o = done;
endmodule

// ===== src/umaf_rx.sv
`timescale 1ns/1ps
module umaf_rx
    import umaf_pkg::*;
#(
    parameter int DIV_W = 16
) (
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    input wire logic clk_en_i,
    input wire logic [DIV_W-1:0] baud_div_i,
    input wire logic double_speed_select_i,
    input wire logic [2:0] char_size_select_i,
    input wire logic parity_en_i,
    input wire logic parity_odd_i,
    input wire logic address_filter_enable_i,
    input wire logic data_read_i,
    input wire logic tx_complete_flag_i,
    output logic [8:0] data_buffer_o,
    output logic rx_ninth_bit_o,
    output logic rx_complete_flag_o,
    output logic frame_error_flag_o,
    output logic parity_error_flag_o,
    output logic [7:0] ctrl_status_a_o,
    umaf_link_if.receiver link
);
    // *********************************************************************
    // Sample timing
    // *********************************************************************
    umaf_state_type state;
    umaf_state_type next_state;
    logic [DIV_W-1:0] div_cnt;
    logic [4:0] samp;
    logic [3:0] bit_idx;
    logic [9:0] shreg;
    logic [2:0] votes;
    logic line_q;
    logic [8:0] data_q;
    logic ninth_q;
    logic rxc_q;
    logic fe_q;
    logic pe_q;
    logic [7:0] status_q;

    wire logic tick = (div_cnt == '0);
    wire logic [4:0] spb = double_speed_select_i ? UMAF_SPB_DOUBLE :
        UMAF_SPB_NORMAL;
    wire logic [4:0] s_first = double_speed_select_i ? UMAF_FIRST_DOUBLE :
        UMAF_FIRST_NORMAL;
    wire logic [4:0] s_mid = double_speed_select_i ? UMAF_MID_DOUBLE :
        UMAF_MID_NORMAL;
    wire logic [4:0] s_last = s_mid + 5'h01;
    wire logic nine = (char_size_select_i == UMAF_CSZ_NINE);
    wire logic [3:0] nbits = nine ? UMAF_DATA_MAX :
        (UMAF_DATA_MIN + {2'b00, char_size_select_i[1:0]});
    wire logic [3:0] dp_len = nbits + {3'h0, parity_en_i};
    // majority vote.
    // The last centre sample joins the vote on the edge that uses it.
    wire logic [2:0] next_votes = {votes[1:0], link.serial_line};
    wire logic vote = (next_votes[0] & next_votes[1])
        | (next_votes[1] & next_votes[2]) | (next_votes[0] & next_votes[2]);
    wire logic in_window = (samp == s_first) || (samp == s_mid)
        || (samp == s_last);
    wire logic bit_done = tick && (samp == s_last);
    wire logic [9:0] aligned = shreg >> (UMAF_DP_MAX - dp_len);
    wire logic [8:0] dmask = 9'h1FF >> (4'h9 - nbits);
    wire logic [8:0] rx_data = aligned[8:0] & dmask;
    wire logic rx_par = aligned[nbits];
    wire logic par_bad = parity_en_i & (^rx_data ^ parity_odd_i ^ rx_par);
    wire logic frame_type = nine ? rx_data[8] : vote;
    wire logic is_addr = frame_type;
    wire logic accept = !address_filter_enable_i || is_addr;
    wire logic frame_end = (state == UMAF_STOP) && bit_done;
    wire logic store = frame_end && accept;
    wire logic [7:0] next_status = {rxc_q | store, tx_complete_flag_i,
        1'b0, fe_q, 1'b0, pe_q, 1'b0, address_filter_enable_i};

    // *********************************************************************
    // Receive state machine
    // *********************************************************************
    // Next state follows edge detection and bit counting.
    always_comb begin
        next_state = state;
        unique case (state)
            UMAF_IDLE: begin
                if (line_q && !link.serial_line) begin
                    next_state = UMAF_START;
                end
            end
            UMAF_START: begin
                if (bit_done) begin
                    next_state = vote ? UMAF_IDLE : UMAF_BITS;
                end
            end
            UMAF_BITS: begin
                if (bit_done && (bit_idx == dp_len - 4'h1)) begin
                    next_state = UMAF_STOP;
                end
            end
            UMAF_STOP: begin
                if (bit_done) begin
                    next_state = UMAF_IDLE;
                end
            end
        endcase
    end

    // Divider, sample counter and shift register.
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state <= UMAF_IDLE;
            div_cnt <= UMAF_DIV_RESET[DIV_W-1:0];
            samp <= 5'h00;
            bit_idx <= 4'h0;
            shreg <= 10'h000;
            votes <= 3'h0;
            line_q <= 1'b1;
        end else if (clk_en_i) begin
            state <= next_state;
            line_q <= link.serial_line;
            if (state == UMAF_IDLE) begin
                div_cnt <= baud_div_i;
                samp <= 5'h01;
                bit_idx <= 4'h0;
            end else if (tick) begin
                div_cnt <= baud_div_i;
                if (in_window) begin
                    votes <= next_votes;
                end
                // Restart sampling right after the last vote sample.
                samp <= (samp == s_last) ? (s_last - spb + 5'h01) :
                    samp + 5'h01;
                if (bit_done && state == UMAF_BITS) begin
                    shreg <= {vote, shreg[9:1]};
                    bit_idx <= bit_idx + 4'h1;
                end
            end else begin
                div_cnt <= div_cnt - 1'b1;
            end
        end
    end

    // Receive buffer and flags; a new frame wins over a read.
    // accepted frame stored, flag set.
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            data_q <= UMAF_DATA_RESET;
            ninth_q <= 1'b0;
            rxc_q <= 1'b0;
            fe_q <= 1'b0;
            pe_q <= 1'b0;
            status_q <= 8'h00;
        end else if (clk_en_i) begin
            status_q <= next_status;
            if (store) begin
                data_q <= rx_data;
                ninth_q <= rx_data[8] & nine;
                rxc_q <= 1'b1;
                fe_q <= ~vote;
                pe_q <= par_bad;
            end else if (data_read_i) begin
                rxc_q <= 1'b0;
            end
        end
    end

    assign data_buffer_o = data_q;
    assign rx_ninth_bit_o = ninth_q;
    assign rx_complete_flag_o = rxc_q;
    assign frame_error_flag_o = fe_q;
    assign parity_error_flag_o = pe_q;
    assign ctrl_status_a_o = status_q;
endmodule

// ===== verification/umaf_chk.sv
`timescale 1ns/1ps
// *****************************************************************
// Checks on the serial line and the receiver status
// *****************************************************************
module umaf_chk
    import umaf_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    input wire logic clk_en_i,
    input wire logic serial_line,
    input wire logic tx_start_i,
    input wire logic tx_busy_o,
    input wire logic tx_complete_flag_o,
    input wire logic tx_complete_flag_i,
    input wire logic [2:0] char_size_select_i,
    input wire logic address_filter_enable_i,
    input wire logic data_read_i,
    input wire logic rx_ninth_bit_o,
    input wire logic rx_complete_flag_o,
    input wire logic frame_error_flag_o,
    input wire logic [7:0] ctrl_status_a_o
);
    // All checks share one clock and are held off during reset and freeze.
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!resetn_i || !clk_en_i);
    a_start_goes_low: assert property (tx_start_i && !tx_busy_o
        |=> !serial_line && tx_busy_o) else $error("start not taken");
    a_idle_line_high: assert property (!tx_busy_o |-> serial_line)
        else $error("line low while sender idle");
    a_done_one_cycle: assert property (tx_complete_flag_o
        |=> !tx_complete_flag_o) else $error("done pulse too long");
    a_rx_flag_sticky: assert property (rx_complete_flag_o &&
        !data_read_i |=> rx_complete_flag_o) else $error("flag lost");
    a_rx_flag_clear: assert property (data_read_i
        |=> !rx_complete_flag_o) else $error("flag not cleared");
    a_filter_status: assert property (1'b1 |=>
        ctrl_status_a_o[0] == $past(address_filter_enable_i))
        else $error("filter bit not in status");
    a_txc_status: assert property (1'b1 |=>
        ctrl_status_a_o[6] == $past(tx_complete_flag_i))
        else $error("sender done not in status");
    a_nine_addr_only: assert property ($rose(rx_complete_flag_o) &&
        address_filter_enable_i && char_size_select_i == UMAF_CSZ_NINE
        |-> rx_ninth_bit_o) else $error("data frame kept");
    a_short_addr_only: assert property ($rose(rx_complete_flag_o) &&
        address_filter_enable_i && char_size_select_i != UMAF_CSZ_NINE
        |-> !frame_error_flag_o) else $error("short data frame kept");
endmodule

// ===== verification/testbench.sv
`timescale 1ns/1ps
// *****************************************************************
// Sender and filtering receiver joined back to back
// *****************************************************************
module testbench
    import umaf_pkg::*;
;
    logic clk_sys_i, resetn_i, clk_en_i, tx_start_i, tx_ninth_bit_i;
    logic stop_bit_select_i, parity_en_i, parity_odd_i, data_read_i;
    logic double_speed_select_i, address_filter_enable_i;
    logic [15:0] div_tx, div_rx;
    logic [2:0] csz_tx, char_size_select_i;
    logic [7:0] tx_data_i, ctrl_status_a_o;
    logic [8:0] data_buffer_o;
    logic tx_busy_o, tx_complete_flag_o, rx_ninth_bit_o;
    logic rx_complete_flag_o, frame_error_flag_o, parity_error_flag_o;
    int bad_count = 0;
    int checked = 0;
    umaf_link_if link_if ();
    umaf_tx umaf_tx_inst (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
        .clk_en_i(clk_en_i), .baud_div_i(div_tx),
        .char_size_select_i(csz_tx), .stop_bit_select_i(stop_bit_select_i),
        .parity_en_i(parity_en_i), .parity_odd_i(parity_odd_i),
        .tx_start_i(tx_start_i), .tx_data_i(tx_data_i),
        .tx_ninth_bit_i(tx_ninth_bit_i), .tx_busy_o(tx_busy_o),
        .tx_complete_flag_o(tx_complete_flag_o), .link(link_if.sender));
    umaf_rx umaf_rx_inst (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
        .clk_en_i(clk_en_i), .baud_div_i(div_rx),
        .double_speed_select_i(double_speed_select_i),
        .char_size_select_i(char_size_select_i), .parity_en_i(parity_en_i),
        .parity_odd_i(parity_odd_i), .data_read_i(data_read_i),
        .address_filter_enable_i(address_filter_enable_i),
        .tx_complete_flag_i(tx_complete_flag_o),
        .data_buffer_o(data_buffer_o), .rx_ninth_bit_o(rx_ninth_bit_o),
        .rx_complete_flag_o(rx_complete_flag_o),
        .frame_error_flag_o(frame_error_flag_o),
        .parity_error_flag_o(parity_error_flag_o),
        .ctrl_status_a_o(ctrl_status_a_o), .link(link_if.receiver));
    umaf_chk umaf_chk_inst (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
        .clk_en_i(clk_en_i),
        .serial_line(link_if.serial_line), .tx_start_i(tx_start_i),
        .tx_busy_o(tx_busy_o), .tx_complete_flag_o(tx_complete_flag_o),
        .tx_complete_flag_i(tx_complete_flag_o),
        .char_size_select_i(char_size_select_i),
        .address_filter_enable_i(address_filter_enable_i),
        .data_read_i(data_read_i), .rx_ninth_bit_o(rx_ninth_bit_o),
        .rx_complete_flag_o(rx_complete_flag_o),
        .frame_error_flag_o(frame_error_flag_o),
        .ctrl_status_a_o(ctrl_status_a_o));
    // The clock toggles every half period of 2 ns.
    initial begin
        clk_sys_i = 1'b0;
        forever #2 clk_sys_i = ~clk_sys_i;
    end
    task automatic check(input logic [8:0] got, input logic [8:0] exp);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic stop_test();
        $display("checked %0d, bad %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // Sends one frame and waits for the sender's done pulse.
    task automatic send(input logic [7:0] d, input logic b8);
        int n;
        @(negedge clk_sys_i);
        tx_data_i = d;
        tx_ninth_bit_i = b8;
        tx_start_i = 1'b1;
        @(negedge clk_sys_i);
        tx_start_i = 1'b0;
        n = 0;
        while (tx_complete_flag_o !== 1'b1 && n < 3000) begin
            @(posedge clk_sys_i);
            #1 n++;
        end
        check(n < 3000, 1'b1);
        repeat (8) @(negedge clk_sys_i);
    endtask
    // Checks a kept frame, then reads it out and clears the flag.
    task automatic kept(input logic [8:0] exp, input logic [8:0] msk);
        check(rx_complete_flag_o, 1'b1);
        check(data_buffer_o & msk, exp);
        check(frame_error_flag_o | parity_error_flag_o, 1'b0);
        data_read_i = 1'b1;
        @(negedge clk_sys_i);
        data_read_i = 1'b0;
        @(negedge clk_sys_i);
        check(rx_complete_flag_o, 1'b0);
    endtask
    task automatic t_nine_filter();
        csz_tx = UMAF_CSZ_NINE;
        char_size_select_i = UMAF_CSZ_NINE;
        send(8'h5A, 1'b0);
        kept(9'h05A, 9'h1FF);
        address_filter_enable_i = 1'b1;
        send(8'h33, 1'b0);
        check(rx_complete_flag_o, 1'b0);
        send(8'hC4, 1'b1);
        check(rx_ninth_bit_o, 1'b1);
        kept(9'h1C4, 9'h1FF);
        address_filter_enable_i = 1'b0;
        send(8'h77, 1'b0);
        kept(9'h077, 9'h1FF);
    endtask
    task automatic t_short_filter();
        char_size_select_i = 3'h3;
        stop_bit_select_i = 1'b1;
        address_filter_enable_i = 1'b1;
        csz_tx = 3'h3;
        send(8'h81, 1'b0);
        kept(9'h081, 9'h0FF);
        csz_tx = UMAF_CSZ_NINE;
        send(8'h66, 1'b0);
        check(rx_complete_flag_o, 1'b0);
        // A kept zero first stop flags a frame error that a drop keeps.
        address_filter_enable_i = 1'b0;
        send(8'h66, 1'b0);
        check({rx_complete_flag_o, frame_error_flag_o}, 2'b11);
        data_read_i = 1'b1;
        @(negedge clk_sys_i);
        data_read_i = 1'b0;
        address_filter_enable_i = 1'b1;
        send(8'h55, 1'b0);
        check({rx_complete_flag_o, frame_error_flag_o}, 2'b01);
        address_filter_enable_i = 1'b0;
        stop_bit_select_i = 1'b0;
    endtask
    task automatic t_sizes();
        logic [2:0] c;
        logic [8:0] m;
        parity_en_i = 1'b1;
        for (int k = 0; k < 5; k++) begin
            c = (k == 4) ? UMAF_CSZ_NINE : 3'(k);
            m = (k == 4) ? 9'h1FF : 9'((1 << (k + 5)) - 1);
            csz_tx = c;
            char_size_select_i = c;
            send(8'hA5, 1'b1);
            kept(9'h1A5 & m, m);
        end
        parity_en_i = 1'b0;
    endtask
    task automatic t_double();
        double_speed_select_i = 1'b1;
        div_rx = 16'h0003;
        send(8'h3C, 1'b1);
        // A frozen clock enable must keep the flag through a read.
        clk_en_i = 1'b0;
        data_read_i = 1'b1;
        @(negedge clk_sys_i);
        data_read_i = 1'b0;
        clk_en_i = 1'b1;
        check(rx_complete_flag_o, 1'b1);
        kept(9'h13C, 9'h1FF);
        double_speed_select_i = 1'b0;
        div_rx = 16'h0001;
    endtask
    // Stops a hung run well after the frames should have finished.
    initial begin
        #200000;
        bad_count++;
        stop_test();
    end
    // Reset, then the scenarios in turn.
    initial begin
        {tx_start_i, tx_ninth_bit_i, stop_bit_select_i, parity_en_i} = 4'h0;
        {parity_odd_i, data_read_i, double_speed_select_i} = 3'h0;
        address_filter_enable_i = 1'b0;
        clk_en_i = 1'b1;
        div_tx = 16'h0001;
        div_rx = 16'h0001;
        csz_tx = UMAF_CSZ_NINE;
        char_size_select_i = UMAF_CSZ_NINE;
        tx_data_i = 8'h00;
        resetn_i = 1'b0;
        repeat (2) @(negedge clk_sys_i);
        resetn_i = 1'b1;
        @(negedge clk_sys_i);
        t_nine_filter();
        t_short_filter();
        t_sizes();
        t_double();
        stop_test();
    end
endmodule
